/* File: core/flash_block_protect_unit.sv */
/*
 * flash_block_protect_unit: decodes the boundary byte into a protect start
 * address, gates the high-voltage enable of program and erase sequences,
 * and drops to standby when the processor enters wait or stop.
 * Assumes the cpu drives the register port on mclk_i; the boundary byte
 * comes from non-volatile storage, stable and unaffected by reset; the
 * test high voltage level comes from a pin detector on another domain.
 */
// Summary of operation
// - start address = 1, boundary bits, seven zeros
// - protected from start up to FFFF
// - region starts on 128-byte page boundary
// - boundary 00 protects whole array
// - boundary FF protects nothing
// - wait during operation aborts to standby
// - stop during operation aborts to standby
// - standby holds program, erase and high voltage inactive
// - wait or stop while reading changes nothing
// - refuse high voltage on protected target
// - boundary locked once programmed unless test voltage present
`timescale 1ns/100ps
module flash_block_protect_unit
    import flash_protect_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [flash_protect_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [flash_protect_pkg::DATA_W-1:0] reg_rdata_o,
    // non-volatile boundary and test voltage
    input wire logic [7:0] protect_start_bits_i,
    input wire logic test_high_voltage_i,
    // flash array write latch from the cpu
    input wire logic flash_wr_i,
    input wire logic [flash_protect_pkg::ADDR_W-1:0] flash_addr_i,
    // low power entry
    input wire logic wait_i,
    input wire logic stop_i,
    // flash array controls
    output logic program_select_o,
    output logic erase_select_o,
    output logic mass_select_o,
    output logic high_voltage_enable_o,
    output logic boundary_write_ok_o,
    output logic standby_o
);
    import flash_protect_pkg::*;

    // test voltage pin synchroniser
    // the pin is asynchronous, so only the second stage feeds logic
    logic tvolt_meta_q;
    logic tvolt_sync_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tvolt_meta_q <= 1'b0;
            tvolt_sync_q <= 1'b0;
        end else begin
            tvolt_meta_q <= test_high_voltage_i;
            tvolt_sync_q <= tvolt_meta_q;
        end
    end

    // boundary decode, combinational from the non-volatile byte
    logic [15:0] start_addr;
    logic all_open;
    logic boundary_read;
    always_comb begin
        // bit 15 set, bits 14:7 boundary, low bits zero
        // low seven zeros give a 128-byte page start
        start_addr = {1'b1, protect_start_bits_i, 7'h00};
        // all ones leaves the array open
        all_open = (protect_start_bits_i == BOUNDARY_NONE);
        boundary_read = reg_rd_i && (reg_addr_i == OFS_BOUNDARY);
    end

    // sequence state and control bits
    seq_state_t state_q, state_d;
    logic prog_q, prog_d;
    logic ers_q, ers_d;
    logic mass_q, mass_d;
    logic hv_q, hv_d;
    logic [15:0] target_q, target_d;
    logic latched_q, latched_d;
    logic refused_q, refused_d;
    logic aborted_q, aborted_d;
    logic target_prot;
    logic low_power;
    logic ctl_wr;

    always_comb begin
        state_d = state_q;
        prog_d = prog_q;
        ers_d = ers_q;
        mass_d = mass_q;
        hv_d = hv_q;
        target_d = target_q;
        latched_d = latched_q;
        refused_d = refused_q;
        aborted_d = aborted_q;
        low_power = wait_i || stop_i;
        ctl_wr = reg_wr_i && (reg_addr_i == OFS_CONTROL);
        // latched address at or above start is protected
        // upper end fixed at the top of flash
        // zero boundary gives start 8000, the whole array
        target_prot = !all_open && (target_q >= start_addr) && (target_q <= FLASH_TOP);
        // status bits cleared by writing ones
        if (reg_wr_i && (reg_addr_i == OFS_STATUS)) begin
            if (reg_wdata_i[STS_REFUSED]) begin
                refused_d = 1'b0;
            end
            if (reg_wdata_i[STS_ABORTED]) begin
                aborted_d = 1'b0;
            end
        end
        if (ctl_wr) begin
            // program and erase are interlocked, program wins a tie
            prog_d = reg_wdata_i[CTL_PROGRAM];
            ers_d = reg_wdata_i[CTL_ERASE] && !reg_wdata_i[CTL_PROGRAM];
            mass_d = reg_wdata_i[CTL_MASS];
            if (!reg_wdata_i[CTL_HV]) begin
                hv_d = 1'b0;
            end else if (state_q == ST_ARMED && latched_q && (prog_q || ers_q)) begin
                // high voltage refused on a protected target
                if (target_prot) begin
                    refused_d = 1'b1;
                end else begin
                    hv_d = 1'b1;
                end
            end else if (!hv_q) begin
                refused_d = 1'b1;
            end
        end
        if (flash_wr_i && (prog_q || ers_q) && !hv_q) begin
            target_d = flash_addr_i;
            latched_d = 1'b1;
        end
        case (state_q)
            ST_STANDBY: begin
                latched_d = 1'b0;
                if (prog_d || ers_d) begin
                    state_d = ST_SELECT;
                end
            end
            ST_SELECT: begin
                if (boundary_read) begin
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (hv_d) begin
                    state_d = ST_HIGHV;
                end
            end
            ST_HIGHV: begin
                if (!hv_d) begin
                    state_d = ST_STANDBY;
                    prog_d = 1'b0;
                    ers_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_STANDBY;
            end
        endcase
        if (!prog_d && !ers_d && !hv_d && state_q != ST_HIGHV) begin
            state_d = ST_STANDBY;
        end
        // idle reads are left alone on wait or stop
        if (low_power && (prog_q || ers_q || hv_q)) begin
            state_d = ST_STANDBY;
            prog_d = 1'b0;
            ers_d = 1'b0;
            mass_d = 1'b0;
            hv_d = 1'b0;
            latched_d = 1'b0;
            aborted_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_STANDBY;
            prog_q <= 1'b0;
            ers_q <= 1'b0;
            mass_q <= 1'b0;
            hv_q <= 1'b0;
            target_q <= FLASH_BASE;
            latched_q <= 1'b0;
            refused_q <= 1'b0;
            aborted_q <= 1'b0;
        end else begin
            state_q <= state_d;
            prog_q <= prog_d;
            ers_q <= ers_d;
            mass_q <= mass_d;
            hv_q <= hv_d;
            target_q <= target_d;
            latched_q <= latched_d;
            refused_q <= refused_d;
            aborted_q <= aborted_d;
        end
    end

    // outputs and read data
    logic [7:0] rdata_d;
    logic wok_d;
    logic sby_d;
    always_comb begin
        // boundary locked once programmed, unless test voltage
        wok_d = all_open || tvolt_sync_q;
        // standby follows the next state so it lines up with the controls
        sby_d = (state_d == ST_STANDBY);
        rdata_d = UNMAPPED_READ;
        if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_BOUNDARY: rdata_d = protect_start_bits_i;
                OFS_CONTROL: rdata_d = {3'h0, latched_q, hv_q, mass_q, ers_q, prog_q};
                OFS_TARGET_LO: rdata_d = target_q[7:0];
                OFS_TARGET_HI: rdata_d = target_q[15:8];
                OFS_STATUS: rdata_d = {4'h0, (state_q == ST_STANDBY), aborted_q,
                    refused_q, target_prot};
                OFS_START_LO: rdata_d = start_addr[7:0];
                OFS_START_HI: rdata_d = start_addr[15:8];
                default: rdata_d = UNMAPPED_READ;
            endcase
        end
    end

    logic [7:0] rdata_q;
    logic wok_q;
    logic sby_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_q <= DATA_ZERO;
            wok_q <= 1'b0;
            sby_q <= 1'b1;
        end else begin
            rdata_q <= rdata_d;
            wok_q <= wok_d;
            sby_q <= sby_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign program_select_o = prog_q;
    assign erase_select_o = ers_q;
    assign mass_select_o = mass_q;
    assign high_voltage_enable_o = hv_q;
    assign boundary_write_ok_o = wok_q;
    assign standby_o = sby_q;

    // checks on the boundary decode and lock, the protect gating and the abort path
    a_hv_not_protected: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(hv_q) |-> !$past(target_prot))
        else $error("high voltage set on protected target");
    a_wait_abort: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wait_i && hv_q) |=> (!hv_q && !prog_q && !ers_q))
        else $error("wait did not abort operation");
    a_stop_abort: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (stop_i && (prog_q || ers_q)) |=> (state_q == ST_STANDBY && aborted_q))
        else $error("stop did not abort operation");
    a_standby_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (state_q == ST_STANDBY) |-> !hv_q)
        else $error("high voltage active in standby");
    // watched at the read port, so a broken decode cannot hide behind itself
    a_start_format: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_addr_i == OFS_START_HI) ##1 $stable(protect_start_bits_i)
        |-> (rdata_q == {1'b1, protect_start_bits_i[7:1]}))
        else $error("start address malformed");
    a_page_start: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_addr_i == OFS_START_LO) ##1 $stable(protect_start_bits_i)
        |-> (rdata_q == {protect_start_bits_i[0], 7'h00}))
        else $error("start address off a page boundary");
    a_open_none: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        all_open |-> !target_prot)
        else $error("open boundary still protects");
    a_zero_all: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (protect_start_bits_i == BOUNDARY_ALL && target_q[15]) |-> target_prot)
        else $error("zero boundary leaves a hole");
    a_idle_lowpower: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (low_power && !prog_q && !ers_q && !hv_q) |=> !aborted_q || $past(aborted_q))
        else $error("idle low power flagged abort");
    a_lock_boundary: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!all_open && !tvolt_sync_q) |=> !wok_q)
        else $error("boundary write allowed while locked");
    a_refuse_unread: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ctl_wr && reg_wdata_i[CTL_HV] && state_q == ST_SELECT) |=> (!hv_q && refused_q))
        else $error("high voltage set without boundary read");
    c_program_hv: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        prog_q && $rose(hv_q));
    c_mass_erase: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        mass_q && ers_q && $rose(hv_q));
    c_refused: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(refused_q));
    c_aborted: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(aborted_q));
endmodule : flash_block_protect_unit

/* File: core/flash_protect_pkg.sv */
/*
 * flash_protect_pkg: register offsets, field positions, reset values and
 * encodings shared by the flash block protect unit.
 * Assumes a plain address/strobe register port with 8-bit data.
 */
package flash_protect_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // register port offsets
    localparam logic [3:0] OFS_BOUNDARY = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h1;
    localparam logic [3:0] OFS_TARGET_LO = 4'h2;
    localparam logic [3:0] OFS_TARGET_HI = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_START_LO = 4'h5;
    localparam logic [3:0] OFS_START_HI = 4'h6;
    // control register fields
    localparam int CTL_PROGRAM = 0;
    localparam int CTL_ERASE = 1;
    localparam int CTL_MASS = 2;
    localparam int CTL_HV = 3;
    localparam int CTL_LATCH = 4;
    // status register fields
    localparam int STS_PROTECTED = 0;
    localparam int STS_REFUSED = 1;
    localparam int STS_ABORTED = 2;
    localparam int STS_STANDBY = 3;
    // boundary value encodings, flash limits and data values
    localparam logic [7:0] BOUNDARY_ALL = 8'h00;
    localparam logic [7:0] BOUNDARY_NONE = 8'hFF;
    localparam logic [15:0] FLASH_TOP = 16'hFFFF;
    localparam logic [15:0] FLASH_BASE = 16'h8000;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // sequence states, one-hot
    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_SELECT = 4'h2,
        ST_ARMED = 4'h4,
        ST_HIGHV = 4'h8
    } seq_state_t;
endpackage : flash_protect_pkg

/* File: sim/flash_cpu_model.sv */
/*
 * flash_cpu_model: behavioural cpu driving the register port, flash array
 * writes and wait/stop entry for the block protect unit.
 * Assumes one clock and read data standing the cycle after the strobe.
 */
`timescale 1ns/100ps
module flash_cpu_model
    import flash_protect_pkg::*;
(
    // clock and read data
    input wire logic mclk_i,
    input wire logic [7:0] reg_rdata_i,
    // register port
    output logic [3:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    // flash write and low power entry
    output logic flash_wr_o,
    output logic [15:0] flash_addr_o,
    output logic wait_o,
    output logic stop_o
);
    // quiet bus at time zero
    initial begin
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
        {flash_wr_o, flash_addr_o, wait_o, stop_o} = '0;
    end

    // one write strobe cycle
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
    endtask : reg_wr

    // read data is only valid in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
    endtask : reg_rd

    // select, boundary read, latch, high voltage; gap makes a slow cpu
    task automatic run_seq(input logic [7:0] mode, input logic [15:0] t, input bit rd_bnd,
        input int gap);
        logic [7:0] d;
        reg_wr(OFS_CONTROL, mode);
        repeat (gap) @(posedge mclk_i);
        if (rd_bnd) reg_rd(OFS_BOUNDARY, d);
        @(posedge mclk_i);
        flash_wr_o <= 1'b1;
        flash_addr_o <= t;
        @(posedge mclk_i);
        flash_wr_o <= 1'b0;
        flash_addr_o <= ~t; // stale address never lingers
        repeat (gap) @(posedge mclk_i);
        reg_wr(OFS_CONTROL, mode | 8'h08);
    endtask : run_seq

    // wait (s=0) or stop (s=1) held for n cycles
    task automatic low_power(input bit s, input int n);
        @(posedge mclk_i);
        wait_o <= !s;
        stop_o <= s;
        repeat (n) @(posedge mclk_i);
        wait_o <= 1'b0;
        stop_o <= 1'b0;
    endtask : low_power
endmodule : flash_cpu_model

/* File: sim/flash_block_protect_unit_tb_top.sv */
/*
 * flash_block_protect_unit_tb_top: self-checking bench with random and corner
 * boundaries, protected targets, refusals and low power aborts.
 * Assumes the cpu model owns the register port and flash write lines.
 */
`timescale 1ns/100ps
module flash_block_protect_unit_tb_top;
    import flash_protect_pkg::*;
    logic mclk_i, rst_n_i, test_high_voltage_i, reg_wr_i, reg_rd_i, flash_wr_i;
    logic wait_i, stop_i, program_select_o, erase_select_o, mass_select_o;
    logic high_voltage_enable_o, boundary_write_ok_o, standby_o;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, protect_start_bits_i;
    logic [15:0] flash_addr_i;
    logic [4:0] ctl_w;
    int errors = 0;
    int check_count = 0;

    assign ctl_w = {program_select_o, erase_select_o, mass_select_o,
        high_voltage_enable_o, standby_o};

    flash_block_protect_unit dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .protect_start_bits_i(protect_start_bits_i),
        .test_high_voltage_i(test_high_voltage_i), .flash_wr_i(flash_wr_i),
        .flash_addr_i(flash_addr_i), .wait_i(wait_i), .stop_i(stop_i),
        .program_select_o(program_select_o), .erase_select_o(erase_select_o),
        .mass_select_o(mass_select_o), .high_voltage_enable_o(high_voltage_enable_o),
        .boundary_write_ok_o(boundary_write_ok_o), .standby_o(standby_o));

    flash_cpu_model cpu_u (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .flash_wr_o(flash_wr_i), .flash_addr_o(flash_addr_i),
        .wait_o(wait_i), .stop_o(stop_i));

    // 200 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    function automatic logic [15:0] exp_start(input logic [7:0] b);
        return {1'b1, b, 7'h00};
    endfunction : exp_start

    function automatic logic exp_prot(input logic [7:0] b, input logic [15:0] t);
        return (b != BOUNDARY_NONE) && (t >= exp_start(b));
    endfunction : exp_prot

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        logic [7:0] d;
        cpu_u.reg_rd(a, d);
        chk({8'h00, d}, exp);
    endtask : rdc

    // boundary byte is a level; give the decode and registered outputs two edges
    task automatic setb(input logic [7:0] b);
        @(posedge mclk_i);
        protect_start_bits_i <= b;
        repeat (2) @(posedge mclk_i);
    endtask : setb

    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    // hang guard
    initial begin
        repeat (100000) @(posedge mclk_i);
        errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        logic [7:0] b, d;
        logic [15:0] t, s;
        logic [7:0] tbl [0:5];
        tbl = '{8'h00, 8'h01, 8'h02, 8'h7F, 8'hFE, 8'hFF};
        void'($urandom(32'hc7065615));
        rst_n_i = 1'b0;
        protect_start_bits_i = 8'hFF;
        test_high_voltage_i = 1'b0;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        chk(16'(ctl_w), 16'h0001);
        // decode of corner and random boundaries
        for (int i = 0; i < 9; i++) begin
            b = (i < 5) ? tbl[i] : 8'($urandom);
            setb(b);
            s = exp_start(b);
            rdc(OFS_START_LO, {8'h00, s[7:0]});
            rdc(OFS_START_HI, {8'h00, s[15:8]});
        end
        // program and erase at the edges of the region, slow and fast cpu
        for (int i = 0; i < 32; i++) begin
            b = (i < 24) ? tbl[i / 4] : 8'($urandom);
            setb(b);
            s = exp_start(b);
            case (i % 4)
                0: t = (s - 16'h0001) | 16'h8000;
                1: t = s;
                2: t = FLASH_TOP;
                default: t = 16'h8000 | 16'($urandom);
            endcase
            cpu_u.run_seq((i % 2) ? 8'h02 : 8'h01, t, 1'b1, i % 3);
            #1;
            chk(16'(high_voltage_enable_o), 16'(!exp_prot(b, t)));
            rdc(OFS_TARGET_HI, {8'h00, t[15:8]});
            cpu_u.reg_rd(OFS_STATUS, d);
            chk(16'(d[STS_PROTECTED]), 16'(exp_prot(b, t)));
            cpu_u.reg_wr(OFS_CONTROL, 8'h00);
            #1;
            chk(16'(ctl_w), 16'h0001);
        end
        // skipping the boundary read is refused
        setb(8'hFF);
        cpu_u.reg_wr(OFS_STATUS, 8'h06);
        cpu_u.run_seq(8'h01, 16'h9000, 1'b0, 0);
        #1;
        chk(16'(high_voltage_enable_o), 16'h0000);
        cpu_u.reg_rd(OFS_STATUS, d);
        chk(16'(d[STS_REFUSED]), 16'h0001);
        cpu_u.reg_wr(OFS_CONTROL, 8'h00);
        // wait during mass erase, stop during program
        for (int k = 0; k < 2; k++) begin
            cpu_u.reg_wr(OFS_STATUS, 8'h06);
            cpu_u.run_seq(k ? 8'h01 : 8'h06, 16'hC000, 1'b1, 1);
            #1;
            chk(16'(ctl_w), k ? 16'h0012 : 16'h000E);
            cpu_u.low_power(k, 1);
            #1;
            chk(16'(ctl_w), 16'h0001);
            cpu_u.reg_rd(OFS_STATUS, d);
            chk(16'(d[STS_ABORTED]), 16'h0001);
        end
        // low power while only reading leaves the logic alone
        cpu_u.reg_wr(OFS_STATUS, 8'h06);
        cpu_u.low_power(1'b0, 4);
        cpu_u.low_power(1'b1, 4);
        #1;
        chk(16'(ctl_w), 16'h0001);
        cpu_u.reg_rd(OFS_STATUS, d);
        chk(16'(d[STS_ABORTED]), 16'h0000);
        // boundary lock and test voltage
        chk(16'(boundary_write_ok_o), 16'h0001);
        setb(8'h3C);
        #1;
        chk(16'(boundary_write_ok_o), 16'h0000);
        @(posedge mclk_i);
        test_high_voltage_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        #1;
        chk(16'(boundary_write_ok_o), 16'h0001);
        // unmapped offsets read as zero
        for (int a = 7; a < 16; a++) begin
            rdc(4'(a), 16'(UNMAPPED_READ));
        end
        give_verdict();
    end
endmodule : flash_block_protect_unit_tb_top
